// ---- core/mgmt_pkg.sv ----
/*
  Constants for the paged management register bank: register numbers,
  field positions, reset values, frame codes and timing counts.
  Assumes a single 25 MHz system clock shared by every user of the package.
*/
package mgmt_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SOFT_RESET_NS = 400;
  localparam int SOFT_RESET_CYCLES =
    (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [4:0] RA_CTRL        = 5'h00;
  localparam logic [4:0] RA_STAT        = 5'h01;
  localparam logic [4:0] RA_ID_HI       = 5'h02;
  localparam logic [4:0] RA_ID_LO       = 5'h03;
  localparam logic [4:0] RA_ADV         = 5'h04;
  localparam logic [4:0] RA_PARTNER     = 5'h05;
  localparam logic [4:0] RA_EXP         = 5'h06;
  localparam logic [4:0] RA_NP_TX       = 5'h07;
  localparam logic [4:0] RA_GIG_CTRL    = 5'h09;
  localparam logic [4:0] RA_SPEC_CTRL_A = 5'h10;
  localparam logic [4:0] RA_SPEC_STAT   = 5'h11;
  localparam logic [4:0] RA_IRQ_EN      = 5'h12;
  localparam logic [4:0] RA_IRQ_STAT    = 5'h13;
  localparam logic [4:0] RA_SPEC_CTRL_B = 5'h14;
  localparam logic [4:0] RA_RXERR       = 5'h15;
  localparam logic [4:0] RA_PAGE        = 5'h16;
  localparam logic [4:0] RA_GLOBAL_IRQ  = 5'h17;
  localparam logic [4:0] RA_FIBER_MODE  = 5'h10;

  localparam logic [7:0] PAGE_COPPER = 8'h00;
  localparam logic [7:0] PAGE_FIBER  = 8'h01;

  localparam int CTRL_RESET_BIT  = 15;
  localparam int CTRL_LOOP_BIT   = 14;
  localparam int STAT_LINK_BIT   = 2;
  localparam int EXP_PAGE_BIT    = 1;
  localparam int DEFER_LSB       = 5;
  localparam int GIRQ_COPPER_BIT = 0;

  localparam logic [1:0] OP_READ  = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [3:0] PHY_ADDR_HIGH = 4'h0;

  localparam logic [1:0] MODE_1000BX      = 2'b01;
  localparam logic [1:0] MODE_SGMII_SYS   = 2'b10;
  localparam logic [1:0] MODE_SGMII_MEDIA = 2'b11;
  localparam logic [15:0] LAYOUT_1000BX      = 16'hb1a0;
  localparam logic [15:0] LAYOUT_SGMII_SYS   = 16'h0001;
  localparam logic [15:0] LAYOUT_SGMII_MEDIA = 16'h9c01;

  localparam logic [15:0] ID_HIGH_VALUE = 16'h0123; // arbitrary value
  localparam logic [15:0] ID_LOW_VALUE  = 16'h4560; // arbitrary value
  localparam logic [15:0] ADV_RESET     = 16'h0000;
  localparam logic [3:0]  RETAIN_RESET  = 4'h0;
  localparam logic [1:0]  FIBER_MODE_RESET = 2'b01;
  localparam logic [4:0]  SYNC_RESET    = 5'b00010;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_HEAD  = 3'b011,
    ST_TA    = 3'b010,
    ST_DATA  = 3'b110
  } frame_state_t;
endpackage : mgmt_pkg

// ---- core/paged_mgmt_register_bank.sv ----
/*
  Paged management register bank with its two-wire serial front end.
  The clock pin and data pin are oversampled on CLK; the station manager
  must run its management clock well below a quarter of CLK.
  Status conditions and event pulses come from logic on CLK.
*/
// Notes on behaviour
// RQ1: latch-high bits set on condition, hold until read or reset.
// RQ2: latch-low bits clear on low condition, hold until read or reset.
// RQ3: reserved bit positions always read back as zero.
// RQ4: retained fields survive soft reset; only hardware reset restores them.
// RQ5: clear-on-read fields return their value, then clear after the read.
// RQ6: read/write fields start at reset value, return last written value.
// RQ7: read/write-clear fields are writable, cleared by any reset or read.
// RQ8: self-clearing bit starts its function at once, clears when done.
// RQ9: deferred fields are held and only applied at next soft reset.
// RQ10: write-only field takes writes; read-back is not meaningful.
// RQ11: access uses standard two-wire read and write management frames.
// RQ12: page register 22 answers on every page.
// RQ13: page 0 holds copper set at 0-10, 15-21 and summary at 23; the code maps only 0-7, 9, 16-21 and 23 there.
// RQ14: fiber register 4 layout follows fiber mode field bits 1:0.
// RQ15: fiber register 5 layout follows the same mode field.
// RQ16: frames need no preamble; one idle bit between frames suffices.
// RQ17: device address is four zero bits plus a strap caught at reset.
// RQ18: the page register picks which set answers all other registers.
`timescale 1ns/1ps
`default_nettype none
module paged_mgmt_register_bank
  import mgmt_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        MDC,
  input  wire logic        MDIO_IN,
  output var  logic        MDIO_OUT,
  output var  logic        MDIO_OE,
  input  wire logic        ADDR_STRAP,
  input  wire logic        LINK_UP,
  input  wire logic        FIBER_LINK_UP,
  input  wire logic [1:0]  PAGE_RX,
  input  wire logic [15:0] IRQ_EVENT,
  input  wire logic        RX_ERROR,
  input  wire logic [15:0] COPPER_PARTNER_WORD,
  input  wire logic [15:0] FIBER_PARTNER_WORD,
  output var  logic        LOOPBACK,
  output var  logic        FIBER_LOOPBACK,
  output var  logic        SOFT_RESET_ACTIVE,
  output var  logic [1:0]  COPPER_MODE,
  output var  logic [1:0]  TEST_SELECT
);

  logic [4:0]   sync1;
  logic [4:0]   sync2;
  logic [4:0]   sync3;
  logic [4:0]   stable;
  logic [4:0]   pin_bus;
  logic         mdc_rise;
  logic         bit_in;
  frame_state_t state;
  logic [3:0]   cnt;
  logic [11:0]  hdr;
  logic [11:0]  next_hdr;
  logic [15:0]  wr_shift;
  logic [15:0]  rd_shift;
  logic         wr_hit;
  logic         rd_hit;
  logic         addressed;
  logic [2:0]   strap_cnt;
  logic         strap_done;
  logic         phy_addr0;
  logic         rd_now;
  logic         wr_now;
  logic [4:0]   rd_sel;
  logic [15:0]  rd_val;
  logic [15:0]  wr_data;
  logic [7:0]   page;
  logic [15:0]  fiber_layout;
  logic         soft_pulse;
  logic [7:0]   soft_cnt;
  logic [1:0]   link_latch;
  logic [1:0]   page_latch;
  logic [1:0]   rd_stat;
  logic [1:0]   rd_exp;
  logic [15:0]  adv;
  logic [15:0]  np_tx;
  logic [15:0]  gig_ctrl;
  logic [1:0]   defer_staged;
  logic [3:0]   retained;
  logic [15:0]  irq_en;
  logic [15:0]  irq_stat;
  logic [7:0]   rwc_byte;
  logic [15:0]  rx_err_count;
  logic [15:0]  fiber_adv;
  logic [1:0]   fiber_mode;

  // pins: clock, data, strap, copper link, fiber link
  assign pin_bus = {FIBER_LINK_UP, LINK_UP, ADDR_STRAP, MDIO_IN, MDC};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          sync1[gi]  <= SYNC_RESET[gi];
          sync2[gi]  <= SYNC_RESET[gi];
          sync3[gi]  <= SYNC_RESET[gi];
          stable[gi] <= SYNC_RESET[gi];
        end else begin
          sync1[gi] <= pin_bus[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            stable[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  assign mdc_rise = (sync2[0] == sync3[0]) && sync3[0] && !stable[0];
  assign bit_in   = stable[1];
  assign next_hdr = {hdr[10:0], bit_in};
  assign wr_data  = {wr_shift[14:0], bit_in};

  // strap sampled once the synchroniser has settled after reset release
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      strap_cnt  <= 3'h0;
      strap_done <= 1'b0;
      phy_addr0  <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 3'h1;
      // the filtered strap first settles on the fourth edge after release
      if (strap_cnt == 3'h4) begin
        strap_done <= 1'b1;
        phy_addr0  <= stable[2]; // RQ17
      end
    end
  end

  assign addressed = strap_done && (next_hdr[9:5] == {PHY_ADDR_HIGH, phy_addr0}); // RQ17
  assign rd_now = mdc_rise && state == ST_HEAD && cnt == 4'hb && addressed
                  && next_hdr[11:10] == OP_READ;
  assign rd_sel = next_hdr[4:0];
  assign wr_now = mdc_rise && state == ST_DATA && cnt == 4'hf && wr_hit;

  // no preamble is required: a zero bit after idle opens a frame
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state    <= ST_IDLE;
      cnt      <= 4'h0;
      hdr      <= 12'h000;
      wr_shift <= 16'h0000;
      rd_shift <= 16'h0000;
      wr_hit   <= 1'b0;
      rd_hit   <= 1'b0;
      MDIO_OUT <= 1'b1;
      MDIO_OE  <= 1'b0;
    end else if (mdc_rise) begin
      case (state)
        ST_IDLE: begin
          if (!bit_in) begin
            state <= ST_START; // RQ16
          end
        end
        ST_START: begin
          cnt   <= 4'h0;
          state <= bit_in ? ST_HEAD : ST_IDLE;
        end
        ST_HEAD: begin
          hdr <= next_hdr;
          cnt <= cnt + 4'h1;
          if (cnt == 4'hb) begin
            cnt      <= 4'h0;
            state    <= ST_TA;
            rd_hit   <= rd_now; // RQ11
            wr_hit   <= addressed && next_hdr[11:10] == OP_WRITE;
            // writes and foreign frames shift out ones, so the line idles high
            rd_shift <= rd_now ? rd_val : 16'hffff;
          end
        end
        ST_TA: begin
          cnt <= cnt + 4'h1;
          if (rd_hit && cnt == 4'h0) begin
            MDIO_OE  <= 1'b1;
            MDIO_OUT <= 1'b0;
          end
          if (cnt == 4'h1) begin
            cnt   <= 4'h0;
            state <= ST_DATA;
            if (rd_hit) begin
              MDIO_OUT <= rd_shift[15];
              rd_shift <= {rd_shift[14:0], 1'b0};
            end
          end
        end
        ST_DATA: begin
          cnt      <= cnt + 4'h1;
          wr_shift <= wr_data;
          MDIO_OUT <= rd_shift[15];
          rd_shift <= {rd_shift[14:0], 1'b0};
          if (cnt == 4'hf) begin
            state    <= ST_IDLE;
            MDIO_OE  <= 1'b0;
            MDIO_OUT <= 1'b1;
            rd_hit   <= 1'b0;
            wr_hit   <= 1'b0;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    case (fiber_mode)
      MODE_1000BX:      fiber_layout = LAYOUT_1000BX;    // RQ14 RQ15
      MODE_SGMII_SYS:   fiber_layout = LAYOUT_SGMII_SYS;
      MODE_SGMII_MEDIA: fiber_layout = LAYOUT_SGMII_MEDIA;
      default:          fiber_layout = 16'h0000;
    endcase
  end

  // unlisted numbers and unused pages read as zero, except the page register, which answers on every page
  always_comb begin
    rd_val = 16'h0000; // RQ3
    if (rd_sel == RA_PAGE) begin
      rd_val = {8'h00, page}; // RQ12
    end else if (page == PAGE_COPPER) begin // RQ18
      if (rd_sel == RA_CTRL) begin // RQ13
        rd_val = {soft_cnt != 8'h00, LOOPBACK, 14'h0000};
      end else if (rd_sel == RA_STAT) begin
        rd_val = {13'h0000, link_latch[0], 2'b00};
      end else if (rd_sel == RA_ID_HI) begin
        rd_val = ID_HIGH_VALUE;
      end else if (rd_sel == RA_ID_LO) begin
        rd_val = ID_LOW_VALUE;
      end else if (rd_sel == RA_ADV) begin
        rd_val = adv;
      end else if (rd_sel == RA_PARTNER) begin
        rd_val = COPPER_PARTNER_WORD;
      end else if (rd_sel == RA_EXP) begin
        rd_val = {14'h0000, page_latch[0], 1'b0};
      end else if (rd_sel == RA_NP_TX) begin
        rd_val = np_tx;
      end else if (rd_sel == RA_GIG_CTRL) begin
        rd_val = gig_ctrl;
      end else if (rd_sel == RA_SPEC_CTRL_A) begin
        rd_val = {9'h000, defer_staged, 1'b0, retained};
      end else if (rd_sel == RA_SPEC_STAT) begin
        rd_val = {13'h0000, stable[3], 2'b00};
      end else if (rd_sel == RA_IRQ_EN) begin
        rd_val = irq_en;
      end else if (rd_sel == RA_IRQ_STAT) begin
        rd_val = irq_stat;
      end else if (rd_sel == RA_SPEC_CTRL_B) begin
        rd_val = {rwc_byte, 8'h00}; // RQ10
      end else if (rd_sel == RA_RXERR) begin
        rd_val = rx_err_count;
      end else if (rd_sel == RA_GLOBAL_IRQ) begin
        rd_val = {15'h0000, |(irq_stat & irq_en)};
      end
    end else if (page == PAGE_FIBER) begin
      if (rd_sel == RA_CTRL) begin
        rd_val = {soft_cnt != 8'h00, FIBER_LOOPBACK, 14'h0000};
      end else if (rd_sel == RA_STAT) begin
        rd_val = {13'h0000, link_latch[1], 2'b00};
      end else if (rd_sel == RA_ID_HI) begin
        rd_val = ID_HIGH_VALUE;
      end else if (rd_sel == RA_ID_LO) begin
        rd_val = ID_LOW_VALUE;
      end else if (rd_sel == RA_ADV) begin
        rd_val = fiber_adv & fiber_layout; // RQ14
      end else if (rd_sel == RA_PARTNER) begin
        rd_val = FIBER_PARTNER_WORD & fiber_layout; // RQ15
      end else if (rd_sel == RA_EXP) begin
        rd_val = {14'h0000, page_latch[1], 1'b0};
      end else if (rd_sel == RA_FIBER_MODE) begin
        rd_val = {14'h0000, fiber_mode};
      end
    end
  end

  function automatic logic hit(input logic now, input logic [4:0] sel,
                               input logic [7:0] pg, input logic [4:0] ra);
    hit = now && sel == ra && pg == page;
  endfunction

  assign soft_pulse = soft_cnt == 8'h00 && wr_data[CTRL_RESET_BIT]
                      && (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_CTRL)
                      || hit(wr_now, hdr[4:0], PAGE_FIBER, RA_CTRL));

  // soft reset runs a fixed time, the bit reads one until it ends
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      soft_cnt          <= 8'h00;
      SOFT_RESET_ACTIVE <= 1'b0;
    end else if (soft_pulse) begin
      soft_cnt          <= 8'(SOFT_RESET_CYCLES); // RQ8
      SOFT_RESET_ACTIVE <= 1'b1;
    end else if (soft_cnt != 8'h00) begin
      soft_cnt          <= soft_cnt - 8'h01;
      SOFT_RESET_ACTIVE <= soft_cnt != 8'h01; // RQ8
    end
  end

  assign rd_stat = {hit(rd_now, rd_sel, PAGE_FIBER, RA_STAT),
                    hit(rd_now, rd_sel, PAGE_COPPER, RA_STAT)};
  assign rd_exp  = {hit(rd_now, rd_sel, PAGE_FIBER, RA_EXP),
                    hit(rd_now, rd_sel, PAGE_COPPER, RA_EXP)};

  // index 0 copper, 1 fiber
  generate
    for (gi = 0; gi < 2; gi++) begin : g_latch
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          link_latch[gi] <= 1'b0;
          page_latch[gi] <= 1'b0;
        end else begin
          if (!stable[3 + gi]) begin
            link_latch[gi] <= 1'b0; // RQ2
          end else if (rd_stat[gi] || soft_pulse) begin
            link_latch[gi] <= 1'b1;
          end
          if (PAGE_RX[gi]) begin
            page_latch[gi] <= 1'b1; // RQ1
          end else if (rd_exp[gi] || soft_pulse) begin
            page_latch[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // plain read/write words, untouched by soft reset
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      adv       <= ADV_RESET;
      np_tx     <= ADV_RESET;
      gig_ctrl  <= ADV_RESET;
      irq_en    <= 16'h0000;
      page      <= PAGE_COPPER;
      fiber_adv <= ADV_RESET;
      retained  <= RETAIN_RESET;
    end else begin
      if (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_ADV)) adv <= wr_data; // RQ6
      if (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_NP_TX)) np_tx <= wr_data;
      if (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_GIG_CTRL)) gig_ctrl <= wr_data;
      if (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_IRQ_EN)) irq_en <= wr_data; // RQ4
      if (wr_now && hdr[4:0] == RA_PAGE) page <= wr_data[7:0]; // RQ12
      if (hit(wr_now, hdr[4:0], PAGE_FIBER, RA_ADV)) begin
        fiber_adv <= wr_data & fiber_layout; // RQ14
      end
      if (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_SPEC_CTRL_A)) begin
        retained <= wr_data[3:0]; // RQ4
      end
    end
  end

  // loopback bits cleared by soft reset; deferred mode applied there
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      LOOPBACK       <= 1'b0;
      FIBER_LOOPBACK <= 1'b0;
      defer_staged   <= 2'b00;
      COPPER_MODE    <= 2'b00;
      TEST_SELECT    <= 2'b00;
      fiber_mode     <= FIBER_MODE_RESET;
    end else begin
      if (soft_pulse) begin
        LOOPBACK       <= 1'b0;
        FIBER_LOOPBACK <= 1'b0;
        COPPER_MODE    <= defer_staged; // RQ9
      end else begin
        if (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_CTRL)) begin
          LOOPBACK <= wr_data[CTRL_LOOP_BIT];
        end
        if (hit(wr_now, hdr[4:0], PAGE_FIBER, RA_CTRL)) begin
          FIBER_LOOPBACK <= wr_data[CTRL_LOOP_BIT];
        end
      end
      if (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_SPEC_CTRL_A)) begin
        defer_staged <= wr_data[DEFER_LSB +: 2]; // RQ9
      end
      if (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_SPEC_CTRL_B)) begin
        TEST_SELECT <= wr_data[1:0]; // RQ10
      end
      if (hit(wr_now, hdr[4:0], PAGE_FIBER, RA_FIBER_MODE)) begin
        fiber_mode <= wr_data[1:0];
      end
    end
  end

  // events arriving with the clearing read are kept: set wins
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      irq_stat     <= 16'h0000;
      rwc_byte     <= 8'h00;
      rx_err_count <= 16'h0000;
    end else begin
      if (hit(rd_now, rd_sel, PAGE_COPPER, RA_IRQ_STAT) || soft_pulse) begin
        irq_stat <= IRQ_EVENT; // RQ5
      end else begin
        irq_stat <= irq_stat | IRQ_EVENT;
      end
      if (hit(rd_now, rd_sel, PAGE_COPPER, RA_SPEC_CTRL_B) || soft_pulse) begin
        rwc_byte <= 8'h00; // RQ7
      end else if (hit(wr_now, hdr[4:0], PAGE_COPPER, RA_SPEC_CTRL_B)) begin
        rwc_byte <= wr_data[15:8]; // RQ7
      end
      // counter saturates instead of wrapping
      if (hit(rd_now, rd_sel, PAGE_COPPER, RA_RXERR) || soft_pulse) begin
        rx_err_count <= {15'h0000, RX_ERROR}; // RQ5
      end else if (RX_ERROR && rx_err_count != 16'hffff) begin
        rx_err_count <= rx_err_count + 16'h0001;
      end
    end
  end

endmodule : paged_mgmt_register_bank
`default_nettype wire

// ---- bench/mgmt_station_model.sv ----
/*
  Station manager model: makes the management clock and drives frames.
  Assumes CLK is the bank's clock; MDC and the model's own drive change on falling CLK edges.
*/
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model
  import mgmt_pkg::*;
(
  input  wire logic CLK,
  input  wire logic MDIO_OUT,
  input  wire logic MDIO_OE,
  output var  logic MDC,
  output var  logic MDIO_IN
);
  logic drive;
  int   half;
  // the pull-up holds the line high whenever nobody drives it
  assign MDIO_IN = (MDIO_OE === 1'b1) ? MDIO_OUT : drive;
  initial begin
    MDC = 1'b0;
    drive = 1'b1;
    half = 8;
  end
  task automatic xfer(input logic [1:0] op, input logic phy,
                      input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [31:0] f;
    // no preamble: the frame opens straight with its start bits
    f = {2'b01, op, PHY_ADDR_HIGH, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 31; i >= 0; i--) begin
      drive = (op == OP_READ && i < 18) ? 1'b1 : f[i];
      repeat (half) @(negedge CLK);
      MDC = 1'b1;
      if (i < 16) rd[i] = MDIO_IN;
      repeat (half) @(negedge CLK);
      MDC = 1'b0;
    end
    drive = 1'b1;
    // one idle bit, the least allowed between frames
    repeat (2 * half) @(negedge CLK);
  endtask : xfer
endmodule : mgmt_station_model
`default_nettype wire

// ---- bench/paged_mgmt_register_bank_assertions.sv ----
/*
  Checker for the paged management register bank.
  Sees only the top ports; bound to every instance of the top.
*/
`timescale 1ns/1ps
`default_nettype none
module paged_mgmt_register_bank_assertions
  import mgmt_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       MDC,
  input wire logic       MDIO_OUT,
  input wire logic       MDIO_OE,
  input wire logic       LOOPBACK,
  input wire logic       FIBER_LOOPBACK,
  input wire logic       SOFT_RESET_ACTIVE,
  input wire logic [1:0] COPPER_MODE,
  input wire logic [1:0] TEST_SELECT
);
  logic [4:0] run;
  // clocks spent so far in the current soft reset
  always_ff @(posedge CLK) begin
    if (!RESETN || !SOFT_RESET_ACTIVE) run <= 5'h00;
    else run <= run + 5'h01;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  property p_quiet;
    disable iff (1'b0) !RESETN |=> !MDIO_OE && MDIO_OUT && !LOOPBACK &&
      !FIBER_LOOPBACK && !SOFT_RESET_ACTIVE && COPPER_MODE == 2'h0 &&
      TEST_SELECT == 2'h0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("outputs not at reset values");
  property p_idle_high; !MDIO_OE |-> MDIO_OUT; endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("data out low while not driving");
  property p_ta_zero; $rose(MDIO_OE) |-> !MDIO_OUT; endproperty
  a_ta_zero: assert property (p_ta_zero)
    else $error("turnaround bit not zero");
  property p_oe_hold; $rose(MDIO_OE) |-> MDIO_OE [*8]; endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("read drive too short");
  property p_oe_mdc; $rose(MDIO_OE) |-> $past(MDC, 3); endproperty
  a_oe_mdc: assert property (p_oe_mdc)
    else $error("drive not tied to a clock rise");
  property p_sr_len;
    $fell(SOFT_RESET_ACTIVE) |-> run == SOFT_RESET_CYCLES;
  endproperty
  a_sr_len: assert property (p_sr_len)
    else $error("soft reset length wrong");
  property p_sr_loop;
    $fell(SOFT_RESET_ACTIVE) |-> !LOOPBACK && !FIBER_LOOPBACK;
  endproperty
  a_sr_loop: assert property (p_sr_loop)
    else $error("loopback survived soft reset");
  property p_retain; SOFT_RESET_ACTIVE |-> $stable(TEST_SELECT); endproperty
  a_retain: assert property (p_retain)
    else $error("retained field changed in soft reset");
  property p_defer;
    $changed(COPPER_MODE) |-> SOFT_RESET_ACTIVE || $past(SOFT_RESET_ACTIVE);
  endproperty
  a_defer: assert property (p_defer)
    else $error("mode applied outside soft reset");
  c_read: cover property ($rose(MDIO_OE));
  c_soft: cover property ($fell(SOFT_RESET_ACTIVE));
  c_mode: cover property ($changed(COPPER_MODE));
endmodule : paged_mgmt_register_bank_assertions
bind paged_mgmt_register_bank paged_mgmt_register_bank_assertions u_chk (
  .CLK(CLK), .RESETN(RESETN), .MDC(MDC), .MDIO_OUT(MDIO_OUT),
  .MDIO_OE(MDIO_OE), .LOOPBACK(LOOPBACK), .FIBER_LOOPBACK(FIBER_LOOPBACK),
  .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE), .COPPER_MODE(COPPER_MODE),
  .TEST_SELECT(TEST_SELECT)
);
`default_nettype wire

// ---- bench/paged_mgmt_register_bank_bench.sv ----
/*
  Self-checking bench for the paged management register bank.
  Assumes the station model for frames and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module paged_mgmt_register_bank_bench
  import mgmt_pkg::*;
();
  logic        CLK;
  logic        RESETN;
  logic        MDC;
  logic        MDIO_IN;
  logic        MDIO_OUT;
  logic        MDIO_OE;
  logic        ADDR_STRAP;
  logic        LINK_UP;
  logic        FIBER_LINK_UP;
  logic [1:0]  PAGE_RX;
  logic [15:0] IRQ_EVENT;
  logic        RX_ERROR;
  logic        LOOPBACK;
  logic        FIBER_LOOPBACK;
  logic        SOFT_RESET_ACTIVE;
  logic [1:0]  COPPER_MODE;
  logic [1:0]  TEST_SELECT;
  logic [15:0] d;
  int          n_fail;
  int          checks;
  int          k;
  logic [4:0]  holes [5] = '{5'h08, 5'h0a, 5'h0b, 5'h0f, 5'h18};
  logic [15:0] lay [4] = '{16'h0000, LAYOUT_1000BX, LAYOUT_SGMII_SYS,
                           LAYOUT_SGMII_MEDIA};
  always #20 CLK = ~CLK;
  paged_mgmt_register_bank u_dut (
    .CLK(CLK), .RESETN(RESETN), .MDC(MDC), .MDIO_IN(MDIO_IN),
    .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE), .ADDR_STRAP(ADDR_STRAP),
    .LINK_UP(LINK_UP), .FIBER_LINK_UP(FIBER_LINK_UP), .PAGE_RX(PAGE_RX),
    .IRQ_EVENT(IRQ_EVENT), .RX_ERROR(RX_ERROR),
    .COPPER_PARTNER_WORD(16'h1234), .FIBER_PARTNER_WORD(16'hffff),
    .LOOPBACK(LOOPBACK), .FIBER_LOOPBACK(FIBER_LOOPBACK),
    .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE), .COPPER_MODE(COPPER_MODE),
    .TEST_SELECT(TEST_SELECT)
  );
  mgmt_station_model u_mgr (
    .CLK(CLK), .MDIO_OUT(MDIO_OUT), .MDIO_OE(MDIO_OE), .MDC(MDC),
    .MDIO_IN(MDIO_IN)
  );
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rdc(input logic [4:0] ra, input logic [15:0] m,
                     input logic [15:0] e);
    logic [15:0] r;
    u_mgr.xfer(OP_READ, 1'b1, ra, 16'h0000, r);
    chk(r & m, e);
  endtask : rdc
  task automatic wr(input logic [4:0] ra, input logic [15:0] v);
    logic [15:0] r;
    u_mgr.xfer(OP_WRITE, 1'b1, ra, v, r);
  endtask : wr
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    #3_200_000;
    n_fail++;
    $display("mismatch at %0t: run timed out", $time);
    report_and_stop();
  end
  initial begin
    CLK = 1'b0;
    RESETN = 1'b0;
    ADDR_STRAP = 1'b1;
    LINK_UP = 1'b1;
    FIBER_LINK_UP = 1'b1;
    PAGE_RX = 2'b00;
    IRQ_EVENT = 16'h0000;
    RX_ERROR = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (5) @(negedge CLK);
    RESETN = 1'b1;
    // strap is caught a few clocks after release
    repeat (8) @(negedge CLK);
    rdc(RA_ID_HI, 16'hffff, ID_HIGH_VALUE);
    rdc(RA_ID_LO, 16'hffff, ID_LOW_VALUE);
    rdc(RA_PARTNER, 16'hffff, 16'h1234);
    rdc(RA_ADV, 16'hffff, ADV_RESET);
    foreach (holes[i]) rdc(holes[i], 16'hffff, 16'h0000);
    u_mgr.half = 12;
    rdc(RA_PAGE, 16'hffff, 16'h0000);
    u_mgr.half = 8;
    // wrong device address: line stays on the pull-up
    u_mgr.xfer(OP_READ, 1'b0, RA_ID_HI, 16'h0000, d);
    chk(d, 16'hffff);
    $display("test identity finished");
    wr(RA_IRQ_EN, 16'hbeef);
    rdc(RA_IRQ_EN, 16'hffff, 16'hbeef);
    u_mgr.xfer(OP_WRITE, 1'b0, RA_IRQ_EN, 16'h0000, d);
    rdc(RA_IRQ_EN, 16'hffff, 16'hbeef);
    wr(RA_ID_HI, 16'h0000);
    rdc(RA_ID_HI, 16'hffff, ID_HIGH_VALUE);
    wr(RA_PAGE, 16'hff02);
    rdc(RA_PAGE, 16'hffff, 16'h0002);
    rdc(RA_ID_HI, 16'hffff, 16'h0000);
    wr(RA_PAGE, 16'h0000);
    $display("test paging finished");
    u_mgr.xfer(OP_READ, 1'b1, RA_STAT, 16'h0000, d);
    rdc(RA_STAT, 16'h0004, 16'h0004);
    LINK_UP = 1'b0;
    repeat (3) @(negedge CLK);
    LINK_UP = 1'b1;
    rdc(RA_STAT, 16'h0004, 16'h0000);
    rdc(RA_STAT, 16'h0004, 16'h0004);
    u_mgr.xfer(OP_READ, 1'b1, RA_EXP, 16'h0000, d);
    rdc(RA_EXP, 16'h0002, 16'h0000);
    PAGE_RX = 2'b01;
    @(negedge CLK);
    PAGE_RX = 2'b00;
    rdc(RA_EXP, 16'h0002, 16'h0002);
    rdc(RA_EXP, 16'h0002, 16'h0000);
    rdc(RA_RXERR, 16'hffff, 16'h0000);
    RX_ERROR = 1'b1;
    repeat (3) @(negedge CLK);
    RX_ERROR = 1'b0;
    rdc(RA_RXERR, 16'hffff, 16'h0003);
    rdc(RA_RXERR, 16'hffff, 16'h0000);
    rdc(RA_GLOBAL_IRQ, 16'h0001, 16'h0000);
    IRQ_EVENT = 16'h0008;
    @(negedge CLK);
    IRQ_EVENT = 16'h0000;
    rdc(RA_GLOBAL_IRQ, 16'h0001, 16'h0001);
    $display("test status finished");
    wr(RA_SPEC_CTRL_B, 16'h5a03);
    chk({14'h0, TEST_SELECT}, 16'h0003);
    // write-only bits give no usable read-back, so they are masked
    rdc(RA_SPEC_CTRL_B, 16'hfffc, 16'h5a00);
    rdc(RA_SPEC_CTRL_B, 16'hfffc, 16'h0000);
    $display("test clear on read finished");
    wr(RA_SPEC_CTRL_A, 16'h0049);
    chk({14'h0, COPPER_MODE}, 16'h0000);
    wr(RA_CTRL, 16'h4000);
    chk({15'h0, LOOPBACK}, 16'h0001);
    wr(RA_CTRL, 16'h8000);
    for (k = 0; k < 40 && SOFT_RESET_ACTIVE === 1'b1; k++) @(negedge CLK);
    if (k == 40) begin
      n_fail++;
      $display("mismatch at %0t: soft reset hung", $time);
      report_and_stop();
    end
    chk({14'h0, COPPER_MODE}, 16'h0002);
    rdc(RA_CTRL, 16'h8000, 16'h0000);
    rdc(RA_SPEC_CTRL_A, 16'h000f, 16'h0009);
    rdc(RA_IRQ_EN, 16'hffff, 16'hbeef);
    chk({14'h0, TEST_SELECT}, 16'h0003);
    $display("test soft reset finished");
    wr(RA_PAGE, {8'h00, PAGE_FIBER});
    rdc(RA_STAT, 16'h0004, 16'h0004);
    FIBER_LINK_UP = 1'b0;
    repeat (3) @(negedge CLK);
    FIBER_LINK_UP = 1'b1;
    rdc(RA_STAT, 16'h0004, 16'h0000);
    rdc(RA_STAT, 16'h0004, 16'h0004);
    for (int m = 0; m < 4; m++) begin
      wr(RA_FIBER_MODE, 16'(m));
      // the advert word is masked by the layout in force when written
      wr(RA_ADV, 16'hffff);
      rdc(RA_ADV, 16'hffff, lay[m]);
      rdc(RA_PARTNER, 16'hffff, lay[m]);
    end
    wr(RA_CTRL, 16'h4000);
    chk({14'h0, FIBER_LOOPBACK, LOOPBACK}, 16'h0002);
    $display("test fiber finished");
    RESETN = 1'b0;
    repeat (5) @(negedge CLK);
    RESETN = 1'b1;
    repeat (8) @(negedge CLK);
    chk({14'h0, TEST_SELECT}, 16'h0000);
    rdc(RA_PAGE, 16'hffff, 16'h0000);
    rdc(RA_SPEC_CTRL_A, 16'h000f, {12'h0, RETAIN_RESET});
    $display("test hardware reset finished");
    report_and_stop();
  end
endmodule : paged_mgmt_register_bank_bench
`default_nettype wire
